// ===== rtl/pst_pkg.sv
// Constants, register map and shared helpers of the synthesizer status and temperature readback bank.
package pst_pkg;
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;
  localparam int          REG_W           = 24;
  // Printed offsets are register indices; byte address is four times the index.
  localparam logic [7:0]  IDX_SAMPLE      = 8'h00;
  localparam logic [7:0]  IDX_THERM_CTRL  = 8'h1E;
  localparam logic [7:0]  IDX_STATUS      = 8'h1F;
  localparam logic [7:0]  IDX_RSVD_A      = 8'h20;
  localparam logic [7:0]  IDX_TEMP        = 8'h21;
  localparam logic [7:0]  IDX_RSVD_B      = 8'h22;
  localparam logic [7:0]  IDX_IRQ_STATUS  = 8'h30;
  localparam logic [7:0]  IDX_IRQ_ENABLE  = 8'h31;
  localparam logic [7:0]  IDX_IRQ_CLEAR   = 8'h32;
  localparam int          SAMPLE_BIT      = 3;
  localparam int          SENS_EN_BIT     = 0;
  localparam int          LOCK_BIT        = 0;
  localparam int          OVF_LSB         = 1;
  localparam int          OVF_W           = 3;
  localparam int          SWEEP_BIT       = 5;
  localparam int          TEMP_W          = 7;
  localparam logic [23:0] RSVD_A_VALUE    = 24'h000020;
  localparam logic [23:0] RSVD_B_VALUE    = 24'h000000;
  localparam logic [23:0] STATUS_RESET    = 24'h000000;
  localparam logic [6:0]  TEMP_RESET      = 7'h00;
  localparam logic [6:0]  TEMP_MAX_CODE   = 7'h07;
  // Sensor temperature arrives as signed tenths of a degree Celsius.
  localparam int          TEMP_OFFSET_DC  = 400;
  localparam int          TEMP_STEP_DC    = 175;
  localparam int          TEMP_SAT_HI_DC  = 825;
  localparam int          TEMP_SAT_LO_DC  = -225;
  localparam int          IRQ_W           = 4;
  localparam int          IRQ_LOCK_LOST   = 0;
  localparam int          IRQ_OVERFLOW    = 1;
  localparam int          IRQ_SWEEP_END   = 2;
  localparam int          IRQ_TEMP_DONE   = 3;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = {2'b00, idx, 2'b00};
  endfunction : byte_addr
endpackage : pst_pkg

// ===== rtl/pst_temp_quant.sv
// Temperature quantiser: tenths of a degree into the saturating 7-bit code.
`timescale 1ns/10ps
`default_nettype none
module pst_temp_quant
  import pst_pkg::*;
(
  input  wire logic signed [15:0]     temp_dc,
  output logic         [pst_pkg::TEMP_W-1:0] code
);
  logic signed [31:0] shifted;
  logic signed [31:0] quot;

  assign shifted = 32'(temp_dc) + TEMP_OFFSET_DC;
  assign quot    = shifted / TEMP_STEP_DC;
  // Below -40 the truncating divide would round toward zero, so the low clamp covers it.
  assign code    = (32'(temp_dc) >= TEMP_SAT_HI_DC) ? TEMP_MAX_CODE :
                   (32'(temp_dc) <= TEMP_SAT_LO_DC) ? TEMP_RESET :
                   quot[TEMP_W-1:0];
endmodule : pst_temp_quant
`default_nettype wire

// ===== rtl/pst_status_bank.sv
// APB register bank for loop status, temperature readback and their interrupts.
`timescale 1ns/10ps
`default_nettype none
module pst_status_bank
  import pst_pkg::*;
(
  input  wire logic                      clock,
  input  wire logic                      reset_n,
  input  wire logic                      clk_en,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [pst_pkg::ADDR_W-1:0] paddr,
  input  wire logic [pst_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [pst_pkg::DATA_W-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      loop_locked,
  input  wire logic [pst_pkg::OVF_W-1:0] modulator_overflow,
  input  wire logic                      sweep_active,
  input  wire logic signed [15:0]        sensor_temp_dc,
  input  wire logic                      sensor_done,
  output logic                           sensor_power_en,
  output logic                           sample_strobe,
  output logic                           irq
);
  import pst_pkg::*;

  logic                  sens_en_ff;
  logic                  nxt_sens_en;
  logic                  lock_ff;
  logic [OVF_W-1:0]      ovf_ff;
  logic                  sweep_ff;
  logic [TEMP_W-1:0]     temp_ff;
  logic [TEMP_W-1:0]     temp_code;
  logic                  strobe_ff;
  logic [IRQ_W-1:0]      irq_stat_ff;
  logic [IRQ_W-1:0]      nxt_irq_stat;
  logic [IRQ_W-1:0]      irq_en_ff;
  logic [IRQ_W-1:0]      irq_events;
  logic [IRQ_W-1:0]      irq_clr;
  logic [DATA_W-1:0]     prdata_ff;
  logic [DATA_W-1:0]     rd_mux;
  logic                  pslverr_ff;
  logic                  setup;
  logic                  wr_en;
  logic                  hit_sample;
  logic                  hit_ctrl;
  logic                  hit_status;
  logic                  hit_rsvd_a;
  logic                  hit_temp;
  logic                  hit_rsvd_b;
  logic                  hit_istat;
  logic                  hit_ien;
  logic                  hit_iclr;
  logic                  mapped;
  logic [REG_W-1:0]      status_word;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == byte_addr(idx));
  endfunction : hit

  // Data is registered in the setup cycle, so every access completes in its first access cycle.
  assign setup      = psel & ~penable;
  assign pready     = 1'b1;
  assign wr_en      = clk_en & psel & penable & pwrite;
  assign hit_sample = hit(paddr, IDX_SAMPLE);
  assign hit_ctrl   = hit(paddr, IDX_THERM_CTRL);
  assign hit_status = hit(paddr, IDX_STATUS);
  assign hit_rsvd_a = hit(paddr, IDX_RSVD_A);
  assign hit_temp   = hit(paddr, IDX_TEMP);
  assign hit_rsvd_b = hit(paddr, IDX_RSVD_B);
  assign hit_istat  = hit(paddr, IDX_IRQ_STATUS);
  assign hit_ien    = hit(paddr, IDX_IRQ_ENABLE);
  assign hit_iclr   = hit(paddr, IDX_IRQ_CLEAR);
  assign mapped     = hit_sample | hit_ctrl | hit_status | hit_rsvd_a | hit_temp |
                      hit_rsvd_b | hit_istat | hit_ien | hit_iclr;

  assign status_word = {18'h00000, sweep_ff, 1'b0, ovf_ff, lock_ff};

  // Read-only and reserved words have no write path at all.
  assign rd_mux = hit_ctrl   ? {31'h00000000, sens_en_ff} :
                  hit_status ? {8'h00, status_word} :
                  hit_rsvd_a ? {8'h00, RSVD_A_VALUE} :
                  hit_temp   ? {25'h0000000, temp_ff} :
                  hit_rsvd_b ? {8'h00, RSVD_B_VALUE} :
                  hit_istat  ? {28'h0000000, irq_stat_ff} :
                  hit_ien    ? {28'h0000000, irq_en_ff} :
                  32'h00000000;

  assign nxt_sens_en = (wr_en & hit_ctrl & pstrb[0]) ? pwdata[SENS_EN_BIT] : sens_en_ff;

  pst_temp_quant u_quant (
    .temp_dc (sensor_temp_dc),
    .code    (temp_code)
  );

  assign irq_events[IRQ_LOCK_LOST] = lock_ff & ~loop_locked;
  assign irq_events[IRQ_OVERFLOW]  = |(modulator_overflow & ~ovf_ff);
  assign irq_events[IRQ_SWEEP_END] = sweep_ff & ~sweep_active;
  assign irq_events[IRQ_TEMP_DONE] = sensor_done & sens_en_ff;
  assign irq_clr      = (wr_en & hit_iclr & pstrb[0]) ? pwdata[IRQ_W-1:0] : 4'h0;
  // A new event wins over a clear in the same cycle.
  assign nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_events;
  assign irq          = |(irq_stat_ff & irq_en_ff);

  assign sensor_power_en = sens_en_ff;
  assign sample_strobe   = strobe_ff;
  assign prdata          = prdata_ff;
  assign pslverr         = pslverr_ff;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sens_en_ff <= 1'b0;
      strobe_ff  <= 1'b0;
      irq_en_ff  <= 4'h0;
    end else if (clk_en) begin
      sens_en_ff <= nxt_sens_en;
      // One-cycle measurement trigger for the sensor, only taken while powered.
      strobe_ff  <= wr_en & hit_sample & pstrb[0] & pwdata[SAMPLE_BIT] & sens_en_ff;
      if (wr_en && hit_ien && pstrb[0]) begin
        irq_en_ff <= pwdata[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lock_ff  <= STATUS_RESET[LOCK_BIT];
      ovf_ff   <= STATUS_RESET[OVF_LSB +: OVF_W];
      sweep_ff <= STATUS_RESET[SWEEP_BIT];
      temp_ff  <= TEMP_RESET;
    end else if (clk_en) begin
      lock_ff  <= loop_locked;
      ovf_ff   <= modulator_overflow;
      sweep_ff <= sweep_active;
      if (sensor_done && sens_en_ff) begin
        temp_ff <= temp_code;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_ff <= 4'h0;
      prdata_ff   <= 32'h00000000;
      pslverr_ff  <= 1'b0;
    end else if (clk_en) begin
      irq_stat_ff <= nxt_irq_stat;
      if (setup) begin
        prdata_ff  <= pwrite ? 32'h00000000 : rd_mux;
        pslverr_ff <= ~mapped;
      end
    end
  end

  a_lock_follows: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en |=> (status_word[LOCK_BIT] == $past(loop_locked)))
    else $error("lock flag does not follow the loop lock input");

  a_ovf_follows: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en |=> (status_word[OVF_LSB +: OVF_W] == $past(modulator_overflow)))
    else $error("overflow flags do not follow the modulator");

  a_sweep_clears: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && !sweep_active) |=> !status_word[SWEEP_BIT])
    else $error("sweep flag stays set after ramp end");

  a_sensor_power: assert property (@(posedge clock) disable iff (!reset_n)
    (wr_en && hit_ctrl && pstrb[0]) |=> (sensor_power_en == $past(pwdata[SENS_EN_BIT])))
    else $error("sensor power does not follow control write");

  a_temp_sat_hi: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && sensor_done && sens_en_ff && sensor_temp_dc >= 16'sd825) |=> (temp_ff == 7'h07))
    else $error("temperature code not saturated high");

  a_temp_sat_lo: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && sensor_done && sens_en_ff && sensor_temp_dc <= -16'sd225) |=> (temp_ff == 7'h00))
    else $error("temperature code not saturated low");

  a_temp_code: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && sensor_done && sens_en_ff && sensor_temp_dc == 16'sd0) |=> (temp_ff == 7'h02))
    else $error("temperature code wrong at zero degrees");

  a_rsvd_read: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && setup && !pwrite && hit_rsvd_a) |=> (prdata == 32'h00000020))
    else $error("reserved word reads wrong value");

  a_ro_write: assert property (@(posedge clock) disable iff (!reset_n)
    (wr_en && (hit_temp || hit_status)) |=> (sensor_power_en == $past(sensor_power_en)))
    else $error("write to read-only word changed control");

  // The bus never stalls, so a master that waits for ready must always see it.
  a_pready_high: assert property (@(posedge clock) disable iff (!reset_n)
    pready)
    else $error("pready dropped");

  // A low clock enable must freeze every piece of state, or software reads drift while the block is parked.
  a_freeze_lock: assert property (@(posedge clock) disable iff (!reset_n)
    !clk_en |=> (lock_ff == $past(lock_ff)))
    else $error("lock flag moved while frozen");

  a_freeze_ovf: assert property (@(posedge clock) disable iff (!reset_n)
    !clk_en |=> (ovf_ff == $past(ovf_ff)))
    else $error("overflow flags moved while frozen");

  a_freeze_sweep: assert property (@(posedge clock) disable iff (!reset_n)
    !clk_en |=> (sweep_ff == $past(sweep_ff)))
    else $error("sweep flag moved while frozen");

  a_freeze_temp: assert property (@(posedge clock) disable iff (!reset_n)
    !clk_en |=> (temp_ff == $past(temp_ff)))
    else $error("temperature code moved while frozen");

  a_freeze_sens: assert property (@(posedge clock) disable iff (!reset_n)
    !clk_en |=> (sens_en_ff == $past(sens_en_ff)))
    else $error("sensor enable moved while frozen");

  a_freeze_irqstat: assert property (@(posedge clock) disable iff (!reset_n)
    !clk_en |=> (irq_stat_ff == $past(irq_stat_ff)))
    else $error("interrupt status moved while frozen");

  a_freeze_ien: assert property (@(posedge clock) disable iff (!reset_n)
    !clk_en |=> (irq_en_ff == $past(irq_en_ff)))
    else $error("interrupt enable moved while frozen");

  a_temp_hold: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && !sensor_done) |=> (temp_ff == $past(temp_ff)))
    else $error("temperature code changed without a sample");

  a_temp_unpowered: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && sensor_done && !sens_en_ff) |=> (temp_ff == $past(temp_ff)))
    else $error("sample taken while sensor is off");

  a_strobe_single: assert property (@(posedge clock) disable iff (!reset_n)
    sample_strobe |=> !sample_strobe)
    else $error("sample strobe longer than one cycle");

  a_strobe_powered: assert property (@(posedge clock) disable iff (!reset_n)
    sample_strobe |-> $past(sensor_power_en))
    else $error("sample strobe while sensor off");

  a_sweep_sets: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && sweep_active) |=> status_word[SWEEP_BIT])
    else $error("sweep flag not set during ramp");

  a_status_rsvd_bits: assert property (@(posedge clock) disable iff (!reset_n)
    (status_word[REG_W-1:SWEEP_BIT+1] == 18'h00000) && !status_word[4])
    else $error("reserved status bits not zero");

  a_rsvd_b_read: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && setup && !pwrite && hit_rsvd_b) |=> (prdata == 32'h00000000))
    else $error("second reserved word reads wrong value");

  a_unmapped_err: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && setup && !mapped) |=> (pslverr && (prdata == 32'h00000000)))
    else $error("unmapped access not refused");

  a_mapped_ok: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && setup && mapped) |=> !pslverr)
    else $error("mapped access flagged as error");

  a_ro_temp_write: assert property (@(posedge clock) disable iff (!reset_n)
    (wr_en && hit_temp && !sensor_done) |=> (temp_ff == $past(temp_ff)))
    else $error("write changed temperature code");

  a_ctrl_read: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && setup && !pwrite && hit_ctrl) |=> (prdata == {31'h00000000, $past(sens_en_ff)}))
    else $error("control word reads wrong value");

  a_temp_read: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && setup && !pwrite && hit_temp) |=> (prdata == {25'h0000000, $past(temp_ff)}))
    else $error("temperature word reads wrong value");

  a_status_read: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && setup && !pwrite && hit_status) |=> (prdata == {8'h00, $past(status_word)}))
    else $error("status word reads wrong value");

  // Every event must land in the sticky status even when a clear hits the same bit.
  a_lock_lost_irq: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && irq_events[IRQ_LOCK_LOST]) |=> irq_stat_ff[IRQ_LOCK_LOST])
    else $error("lock loss not recorded");

  a_ovf_irq: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && irq_events[IRQ_OVERFLOW]) |=> irq_stat_ff[IRQ_OVERFLOW])
    else $error("overflow event not recorded");

  a_sweep_end_irq: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && irq_events[IRQ_SWEEP_END]) |=> irq_stat_ff[IRQ_SWEEP_END])
    else $error("sweep end not recorded");

  a_temp_done_irq: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && sensor_done && sens_en_ff) |=> irq_stat_ff[IRQ_TEMP_DONE])
    else $error("temperature sample not recorded");

  a_irq_clear: assert property (@(posedge clock) disable iff (!reset_n)
    (irq_clr[IRQ_LOCK_LOST] && !irq_events[IRQ_LOCK_LOST]) |=> !irq_stat_ff[IRQ_LOCK_LOST])
    else $error("interrupt clear ignored");

  a_write_reads_zero: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && setup && pwrite) |=> (prdata == 32'h00000000))
    else $error("write cycle returned read data");

  a_temp_mid: assert property (@(posedge clock) disable iff (!reset_n)
    (clk_en && sensor_done && sens_en_ff && sensor_temp_dc == 16'sd500) |=> (temp_ff == 7'h05))
    else $error("temperature code wrong at fifty degrees");
endmodule : pst_status_bank
`default_nettype wire

// ===== bench/pst_status_bank_bench.sv
// Self-checking bench for the status and temperature readback register bank.
`timescale 1ns/10ps
`default_nettype none
module pst_status_bank_bench;
  import pst_pkg::*;
  typedef struct {
    logic lk; logic [2:0] ov; logic sw; logic signed [15:0] t; logic [31:0] st; logic [31:0] tc;
  } pst_row_t;
  localparam logic [11:0] A_STRB = 12'h000, A_CTRL = 12'h078, A_STAT = 12'h07C, A_RSVA = 12'h080;
  localparam logic [11:0] A_TEMP = 12'h084, A_RSVB = 12'h088, A_IST = 12'h0C0, A_IEN = 12'h0C4, A_ICLR = 12'h0C8;
  logic               clock, reset_n, psel, penable, pwrite, loop_locked, sweep_active, sensor_done, clk_en;
  logic        [11:0] paddr;
  logic        [31:0] pwdata, prdata, rd;
  logic               pready, pslverr, sensor_power_en, sample_strobe, irq, er;
  logic        [2:0]  modulator_overflow;
  logic signed [15:0] sensor_temp_dc;
  int                 miscompares, checked, cnt;
  pst_row_t           rows [8];

  pst_status_bank uut (.clock(clock), .reset_n(reset_n), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .loop_locked(loop_locked), .modulator_overflow(modulator_overflow),
    .sweep_active(sweep_active), .sensor_temp_dc(sensor_temp_dc), .sensor_done(sensor_done),
    .sensor_power_en(sensor_power_en), .sample_strobe(sample_strobe), .irq(irq));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // The request is held until pready is seen high at a rising edge; read data is taken at that edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk

  task automatic sample;
    @(posedge clock);
    sensor_done <= 1'b1;
    @(posedge clock);
    sensor_done <= 1'b0;
  endtask : sample

  initial begin
    miscompares = 0; checked = 0; clk_en = 1'b1;
    reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    loop_locked = 1'b0; modulator_overflow = 3'h0; sweep_active = 1'b0; sensor_done = 1'b0; sensor_temp_dc = 16'sh0;
    // Status columns: lock, overflow, sweep, then temperature in tenths with its expected code.
    rows = '{'{1'b1, 3'h0, 1'b0, 16'sd0, 32'h01, 32'h2}, '{1'b0, 3'h5, 1'b1, -16'sd225, 32'h2A, 32'h0},
             '{1'b1, 3'h7, 1'b1, 16'sd825, 32'h2F, 32'h7}, '{1'b0, 3'h2, 1'b0, 16'sd824, 32'h04, 32'h6},
             '{1'b1, 3'h0, 1'b0, -16'sd224, 32'h01, 32'h1}, '{1'b0, 3'h0, 1'b0, 16'sd1000, 32'h0, 32'h7},
             '{1'b0, 3'h0, 1'b0, -16'sd400, 32'h0, 32'h0}, '{1'b0, 3'h0, 1'b0, 16'sd500, 32'h0, 32'h5}};
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    check({31'h0, sensor_power_en}, 32'h0);
    rdchk(A_CTRL, 32'h0);
    rdchk(A_STAT, 32'h0);
    rdchk(A_TEMP, 32'h0);
    rdchk(A_RSVA, 32'h20);
    rdchk(A_RSVB, 32'h0);
    apb(1'b1, A_CTRL, 32'h1);
    @(posedge clock);
    check({31'h0, sensor_power_en}, 32'h1);
    rdchk(A_CTRL, 32'h1);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      loop_locked <= rows[i].lk; modulator_overflow <= rows[i].ov; sweep_active <= rows[i].sw;
      sensor_temp_dc <= rows[i].t;
      sample();
      rdchk(A_STAT, rows[i].st);
      rdchk(A_TEMP, rows[i].tc);
    end
    // Writes to read-only and reserved words must leave them as they were.
    apb(1'b1, A_STAT, 32'hFFFFFF);
    apb(1'b1, A_RSVA, 32'hFFFFFF);
    apb(1'b1, A_TEMP, 32'hFFFFFF);
    apb(1'b1, A_RSVB, 32'hFFFFFF);
    rdchk(A_STAT, 32'h0);
    rdchk(A_RSVA, 32'h20);
    rdchk(A_TEMP, 32'h5);
    rdchk(A_RSVB, 32'h0);
    rdchk(12'hFFC, 32'h0);
    check({31'h0, er}, 32'h1);
    apb(1'b1, A_STRB, 32'h8);
    cnt = 0;
    repeat (4) begin
      @(negedge clock);
      if (sample_strobe === 1'b1) cnt++;
    end
    check(cnt, 32'h1);
    apb(1'b1, A_CTRL, 32'h0);
    @(posedge clock);
    check({31'h0, sensor_power_en}, 32'h0);
    sensor_temp_dc <= 16'sd0;
    sample();
    rdchk(A_TEMP, 32'h5);
    // Interrupt: lock loss while masked, then unmasked, then cleared.
    apb(1'b1, A_IEN, 32'h0);
    apb(1'b1, A_ICLR, 32'hF);
    rdchk(A_IST, 32'h0);
    loop_locked <= 1'b1;
    apb(1'b1, A_IEN, 32'h0);
    loop_locked <= 1'b0;
    rdchk(A_IST, 32'h1);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, A_IEN, 32'h1);
    @(posedge clock);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, A_ICLR, 32'h1);
    @(posedge clock);
    check({31'h0, irq}, 32'h0);
    rdchk(A_IST, 32'h0);
    // A frozen block must not see a lock pulse, so no lock-lost event may appear.
    clk_en <= 1'b0;
    loop_locked <= 1'b1;
    repeat (4) @(posedge clock);
    loop_locked <= 1'b0;
    repeat (2) @(posedge clock);
    clk_en <= 1'b1;
    rdchk(A_IST, 32'h0);
    conclude();
  end
endmodule : pst_status_bank_bench
`default_nettype wire
